// ===== hw/cidt_decoder.sv
`timescale 1ns/10ps
`include "cidt_map.svh"

// Contract
// - Single word: 24 bits, opcode plus operands
// - Only three opcodes span two words
// - Second word carries zero upper byte
// - Lone second word executes as NOP
// - True condition or PC change: two cycles
// - Branches, tables, returns take two/three cycles
// - Taken skip: two or three cycles
// - Double word moves take two cycles
// - Double-word instructions take exactly two cycles
// - File address spans zero to 0x1FFF; bit-file ops decode 12 bits, reaching only 0xFFF
// - Bit select is four bits, 0-15
// - Unsigned literal: 255 byte, 1023 word
// - Signed literal is two's complement -512..511
// - Program address literal always even
// - Five flags, zero flag may be sticky
// - Square pairs only W4..W7 with themselves
// - DSP multiply uses six distinct pairs
// - Work register fields select W0..W15
// - File ops write file or W0
// - Size selects byte, word, dword; word default
// - Debug reserves 80 RAM bytes, two pins
// - Debug link on one of three pairs
module cidt_decoder #(
  parameter logic [12:0] RESV_BYTES = `CIDT_RAM_RESV_BYTES // Debug RAM hold
) (
  input  wire logic                     clk_i,              // 40 MHz clock
  input  wire logic                     rst_i,              // Sync reset
  input  wire logic [4:0]               avs_address_i,      // Byte address
  input  wire logic                     avs_read_i,         // Read request
  input  wire logic                     avs_write_i,        // Write request
  input  wire logic [31:0]              avs_writedata_i,    // Write data
  input  wire logic [3:0]               avs_byteenable_i,   // Byte lanes
  output logic      [31:0]              avs_readdata_o,     // Read data
  output logic                          avs_waitrequest_o,  // Stall master
  input  wire logic                     fetch_valid_i,      // Word offered
  input  wire logic [23:0]              fetch_word_i,       // Program word
  output logic                          fetch_ready_o,      // Word accepted
  input  wire logic                     cond_true_i,        // Test result
  input  wire cidt_pkg::cidt_flag_upd_t flag_upd_i,         // Flag writes
  output logic                          dec_valid_o,        // Decode pulse
  output cidt_pkg::cidt_dec_t           dec_o,              // Decoded fields
  output logic                          nop_cycle_o,        // Extra cycle
  output logic                          squash_o,           // Skipped word
  output cidt_pkg::cidt_flags_t         flags_o,            // Status flags
  output logic                          ram_guard_o,        // Reserved RAM
  output logic      [2:0]               pair_claim_o,       // Pins claimed
  input  wire logic [2:0]               debug_clock_pin_i,  // Clock pins
  input  wire logic [2:0]               debug_data_pin_i,   // Data pins in
  output logic      [2:0]               debug_data_pin_o,   // Data pins out
  output logic      [2:0]               debug_data_pin_oe_o,// Data pin drive
  input  wire logic                     dbg_data_out_i,     // Link data out
  input  wire logic                     dbg_data_drive_i,   // Link drives
  output logic                          dbg_clk_level_o,    // Link clock
  output logic                          dbg_data_level_o    // Link data in
);

  // Opcode byte to class; used for decode and for skip lookahead
  // three double words
  function automatic cidt_pkg::cidt_cls_t cls_of(input logic [7:0] op);
    case (op)
      `CIDT_OP_NOP:       cls_of = cidt_pkg::CIDT_CLS_NOP;
      `CIDT_OP_FILE:      cls_of = cidt_pkg::CIDT_CLS_FILE;
      `CIDT_OP_BIT_FILE:  cls_of = cidt_pkg::CIDT_CLS_BITF;
      `CIDT_OP_BIT_WORK:  cls_of = cidt_pkg::CIDT_CLS_BITW;
      `CIDT_OP_LIT_U:     cls_of = cidt_pkg::CIDT_CLS_LITU;
      `CIDT_OP_LIT_S:     cls_of = cidt_pkg::CIDT_CLS_LITS;
      `CIDT_OP_WORK:      cls_of = cidt_pkg::CIDT_CLS_WORK;
      `CIDT_OP_SQUARE:    cls_of = cidt_pkg::CIDT_CLS_SQR;
      `CIDT_OP_DSP_MUL:   cls_of = cidt_pkg::CIDT_CLS_DSP;
      `CIDT_OP_BRA_COND:  cls_of = cidt_pkg::CIDT_CLS_BRC;
      `CIDT_OP_BRA:       cls_of = cidt_pkg::CIDT_CLS_BRA;
      `CIDT_OP_BRA_COMP:  cls_of = cidt_pkg::CIDT_CLS_BRA;
      `CIDT_OP_CALL_IND:  cls_of = cidt_pkg::CIDT_CLS_IND;
      `CIDT_OP_GOTO_IND:  cls_of = cidt_pkg::CIDT_CLS_IND;
      `CIDT_OP_TABLE:     cls_of = cidt_pkg::CIDT_CLS_TBL;
      `CIDT_OP_RETURN:    cls_of = cidt_pkg::CIDT_CLS_RET;
      `CIDT_OP_RET_INT:   cls_of = cidt_pkg::CIDT_CLS_RET;
      `CIDT_OP_SKIP:      cls_of = cidt_pkg::CIDT_CLS_SKIP;
      `CIDT_OP_MOV_DWORD: cls_of = cidt_pkg::CIDT_CLS_MOVD;
      `CIDT_OP_GOTO:      cls_of = cidt_pkg::CIDT_CLS_DBL;
      `CIDT_OP_CALL:      cls_of = cidt_pkg::CIDT_CLS_DBL;
      `CIDT_OP_MOV_LONG:  cls_of = cidt_pkg::CIDT_CLS_DBL;
      default:            cls_of = cidt_pkg::CIDT_CLS_BAD;
    endcase
  endfunction

  // Total cycles of the fixed-length single-word groups
  function automatic logic [1:0] cycles_of(input cidt_pkg::cidt_cls_t c);
    case (c)
      cidt_pkg::CIDT_CLS_BRA:  cycles_of = `CIDT_CYC_BRANCH;
      cidt_pkg::CIDT_CLS_IND:  cycles_of = `CIDT_CYC_INDIRECT;
      cidt_pkg::CIDT_CLS_TBL:  cycles_of = `CIDT_CYC_TABLE;
      cidt_pkg::CIDT_CLS_RET:  cycles_of = `CIDT_CYC_RETURN;
      cidt_pkg::CIDT_CLS_MOVD: cycles_of = `CIDT_CYC_MOV_DWORD;
      default:                 cycles_of = `CIDT_CYC_SINGLE;
    endcase
  endfunction

  // Field extraction; w2 is the second word of a double-word op
  function automatic cidt_pkg::cidt_dec_t dec_of(input logic [23:0] w,
                                                 input logic [23:0] w2);
    cidt_pkg::cidt_dec_t d;
    d = '0;
    d.opcode = w[23:16];
    d.cls    = cls_of(w[23:16]);
    d.size   = cidt_pkg::CIDT_SZ_WORD;
    case (d.cls)
      cidt_pkg::CIDT_CLS_FILE: begin
        d.to_file   = w[15];
        d.size      = w[14] ? cidt_pkg::CIDT_SZ_BYTE : cidt_pkg::CIDT_SZ_WORD;
        d.file_addr = w[12:0];
      end
      cidt_pkg::CIDT_CLS_BITF: begin
        d.bit_sel   = w[15:12];
        d.file_addr = {1'b0, w[11:0]};
      end
      cidt_pkg::CIDT_CLS_BITW: begin
        d.bit_sel         = w[15:12];
        d.source_work_reg = w[3:0];
      end
      cidt_pkg::CIDT_CLS_LITU: begin
        d.size          = w[14] ? cidt_pkg::CIDT_SZ_BYTE : cidt_pkg::CIDT_SZ_WORD;
        d.dest_work_reg = w[3:0];
        d.ulit10 = w[14] ? (w[13:4] & `CIDT_BYTE_LIT_MAX) : w[13:4];
        d.bad    = w[14] && (w[13:4] > `CIDT_BYTE_LIT_MAX);
      end
      cidt_pkg::CIDT_CLS_LITS: begin
        d.signed_ten_literal        = {{6{w[13]}}, w[13:4]};
        d.dest_work_reg = w[3:0];
      end
      cidt_pkg::CIDT_CLS_WORK: begin
        d.base_work_reg   = w[11:8];
        d.source_work_reg = w[7:4];
        d.dest_work_reg   = w[3:0];
        d.size = cidt_pkg::cidt_size_t'(w[15:14]);
        d.bad  = (w[15:14] == 2'b11);
      end
      cidt_pkg::CIDT_CLS_SQR: begin
        d.source_work_reg = {2'b01, w[3:2]};
        d.base_work_reg   = {2'b01, w[1:0]};
        d.mul_ok = (w[3:2] == w[1:0]);
        d.bad    = (w[3:2] != w[1:0]);
      end
      cidt_pkg::CIDT_CLS_DSP: begin
        d.source_work_reg = {2'b01, w[3:2]};
        d.base_work_reg   = {2'b01, w[1:0]};
        d.mul_ok = (w[3:2] < w[1:0]);
        d.bad    = !(w[3:2] < w[1:0]);
      end
      cidt_pkg::CIDT_CLS_MOVD: begin
        d.size            = cidt_pkg::CIDT_SZ_DWORD;
        d.source_work_reg = w[7:4];
        d.dest_work_reg   = w[3:0];
      end
      cidt_pkg::CIDT_CLS_DBL: begin
        d.prog_addr = {w2[6:0], w[15:1], 1'b0};
        d.bad = w[0] || (w2[23:16] != 8'h00) || (w2[15:7] != 9'h000);
      end
      cidt_pkg::CIDT_CLS_BAD: d.bad = 1'b1;
      default: d.bad = 1'b0;
    endcase
    dec_of = d;
  endfunction

  cidt_pkg::cidt_state_t state_q, state_d;
  logic [1:0]            cnt_q, cnt_d;
  logic                  ready_q, ready_d;
  logic [23:0]           word1_q;
  cidt_pkg::cidt_dec_t   dec_q;
  logic                  dec_valid_q, nop_q, squash_q, guard_q;
  cidt_pkg::cidt_flags_t flags_q;
  logic                  dbg_en_q;
  logic [1:0]            pair_q;
  logic                  illegal_q;
  logic [31:0]           retired_q;
  logic                  wait_q;
  logic [31:0]           rdata_q;
  logic [2:0]            pair_claim_q, data_pin_q, data_oe_q;
  logic [2:0]            clk_s1_q, clk_s2_q, dat_s1_q, dat_s2_q;
  logic                  clk_lvl_q, dat_lvl_q;

  // Fetch decode: the class is read once per offered word
  wire                      take      = fetch_valid_i & ready_q;
  wire cidt_pkg::cidt_cls_t cls_w     = cls_of(fetch_word_i[23:16]);
  wire                      in_idle   = (state_q == cidt_pkg::CIDT_ST_IDLE);
  wire                      in_word2  = (state_q == cidt_pkg::CIDT_ST_WORD2);
  wire                      in_skip   = (state_q == cidt_pkg::CIDT_ST_SKIP) ||
                                        (state_q == cidt_pkg::CIDT_ST_SKIP2);
  wire                      is_dbl    = (cls_w == cidt_pkg::CIDT_CLS_DBL);
  wire [1:0]                extra_w   = (cls_w == cidt_pkg::CIDT_CLS_BRC) ?
                                        {1'b0, cond_true_i} :
                                        cycles_of(cls_w) - 2'h1;
  wire                      dec_fire  = take && ((in_idle && !is_dbl) || in_word2);
  wire cidt_pkg::cidt_dec_t dec_w     = in_word2 ? dec_of(word1_q, fetch_word_i)
                                                 : dec_of(fetch_word_i, 24'h0);
  wire                      uses_file = (dec_w.cls == cidt_pkg::CIDT_CLS_FILE) ||
                                        (dec_w.cls == cidt_pkg::CIDT_CLS_BITF);

  // Sequencer: extra cycles withhold ready so the fetch really stalls
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ready_d = ready_q;
    case (state_q)
      cidt_pkg::CIDT_ST_IDLE: begin
        if (take) begin
          if (is_dbl) begin
            state_d = cidt_pkg::CIDT_ST_WORD2;
          end else if (cls_w == cidt_pkg::CIDT_CLS_SKIP && cond_true_i) begin
            state_d = cidt_pkg::CIDT_ST_SKIP;
          end else if (extra_w != 2'h0) begin
            state_d = cidt_pkg::CIDT_ST_STALL;
            cnt_d   = extra_w;
            ready_d = 1'b0;
          end
        end
      end
      cidt_pkg::CIDT_ST_WORD2: begin
        if (take) begin
          state_d = cidt_pkg::CIDT_ST_IDLE;
        end
      end
      cidt_pkg::CIDT_ST_STALL: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          state_d = cidt_pkg::CIDT_ST_IDLE;
          ready_d = 1'b1;
        end
      end
      cidt_pkg::CIDT_ST_SKIP: begin
        if (take) begin
          state_d = is_dbl ? cidt_pkg::CIDT_ST_SKIP2 : cidt_pkg::CIDT_ST_IDLE;
        end
      end
      cidt_pkg::CIDT_ST_SKIP2: begin
        if (take) begin
          state_d = cidt_pkg::CIDT_ST_IDLE;
        end
      end
      default: begin
        state_d = cidt_pkg::CIDT_ST_IDLE;
        cnt_d   = 2'h0;
        ready_d = 1'b1;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= cidt_pkg::CIDT_ST_IDLE;
      cnt_q   <= 2'h0;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ready_q <= ready_d;
    end
  end

  // Decode outputs; a lone second word decodes as the zero opcode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word1_q     <= 24'h0;
      dec_q       <= '0;
      dec_valid_q <= 1'b0;
      nop_q       <= 1'b0;
      squash_q    <= 1'b0;
      guard_q     <= 1'b0;
    end else begin
      if (take && in_idle) begin
        word1_q <= fetch_word_i;
      end
      if (dec_fire) begin
        dec_q <= dec_w;
      end
      dec_valid_q <= dec_fire;
      nop_q       <= (state_d == cidt_pkg::CIDT_ST_STALL);
      squash_q    <= take && in_skip;
      guard_q     <= dec_fire && dbg_en_q && uses_file &&
                     (dec_w.file_addr < RESV_BYTES);
    end
  end

  // Flag writes are blocked in NOP and squashed cycles
  // no state change
  wire flag_block = nop_q || squash_q ||
                    (dec_valid_q && dec_q.cls == cidt_pkg::CIDT_CLS_NOP);
  wire [4:0] flag_we = flag_block ? 5'h00 : flag_upd_i.we;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      if (flag_we[4]) flags_q.c  <= flag_upd_i.val.c;
      if (flag_we[3]) flags_q.dc <= flag_upd_i.val.dc;
      if (flag_we[2]) flags_q.n  <= flag_upd_i.val.n;
      if (flag_we[1]) flags_q.ov <= flag_upd_i.val.ov;
      // Sticky zero can only be cleared by a nonzero result
      if (flag_we[0]) flags_q.z  <= flag_upd_i.z_sticky ?
                                    (flags_q.z & flag_upd_i.val.z) :
                                    flag_upd_i.val.z;
    end
  end

  // Avalon slave: every access answers on the second edge
  wire       req     = avs_read_i | avs_write_i;
  wire       acc     = req & ~wait_q;
  wire       wr_ctrl = acc & avs_write_i & avs_byteenable_i[0] &
                       (avs_address_i == `CIDT_REG_CTRL);
  wire       wr_stat = acc & avs_write_i & avs_byteenable_i[2] &
                       (avs_address_i == `CIDT_REG_STATUS);
  wire [1:0] pair_wr = avs_writedata_i[`CIDT_CTRL_PAIR_HI:`CIDT_CTRL_PAIR_LO];
  wire       set_ill = dec_valid_q & dec_q.bad;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address_i)
      `CIDT_REG_CTRL: begin
        rd_mux[`CIDT_CTRL_DBG_EN] = dbg_en_q;
        rd_mux[`CIDT_CTRL_PAIR_HI:`CIDT_CTRL_PAIR_LO] = pair_q;
      end
      `CIDT_REG_STATUS: begin
        rd_mux[`CIDT_STAT_FLAGS_HI:0] = flags_q;
        rd_mux[`CIDT_STAT_STATE_HI:`CIDT_STAT_STATE_LO] = state_q;
        rd_mux[`CIDT_STAT_ILLEGAL] = illegal_q;
      end
      `CIDT_REG_LASTWORD: rd_mux = {8'h00, word1_q};
      `CIDT_REG_RETIRED:  rd_mux = retired_q;
      default:            rd_mux = 32'h0;
    endcase
  end

  // Bus handshake and software-visible registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q    <= 1'b1;
      rdata_q   <= 32'h0;
      dbg_en_q  <= `CIDT_RST_DBG_EN;
      pair_q    <= `CIDT_RST_PAIR;
      illegal_q <= 1'b0;
      retired_q <= 32'h0;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        rdata_q <= rd_mux;
      end
      if (wr_ctrl) begin
        dbg_en_q <= avs_writedata_i[`CIDT_CTRL_DBG_EN];
        if (pair_wr < `CIDT_PAIR_COUNT) pair_q <= pair_wr;
      end
      // A new illegal decode wins over a software clear
      if (set_ill) illegal_q <= 1'b1;
      else if (wr_stat && avs_writedata_i[`CIDT_STAT_ILLEGAL]) illegal_q <= 1'b0;
      if (dec_valid_q) retired_q <= retired_q + 32'h1;
    end
  end

  // Debug pins are foreign to this clock: two stages before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_s1_q <= 3'h0;
      clk_s2_q <= 3'h0;
      dat_s1_q <= 3'h0;
      dat_s2_q <= 3'h0;
    end else begin
      clk_s1_q <= debug_clock_pin_i;
      clk_s2_q <= clk_s1_q;
      dat_s1_q <= debug_data_pin_i;
      dat_s2_q <= dat_s1_q;
    end
  end

  // Selected pair is claimed from the application while debug is on
  wire [2:0] pair_hot = 3'h1 << pair_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pair_claim_q <= 3'h0;
      data_pin_q   <= 3'h0;
      data_oe_q    <= 3'h0;
      clk_lvl_q    <= 1'b0;
      dat_lvl_q    <= 1'b0;
    end else begin
      pair_claim_q <= dbg_en_q ? pair_hot : 3'h0;
      data_pin_q   <= {3{dbg_data_out_i}} & pair_hot;
      data_oe_q    <= {3{dbg_en_q & dbg_data_drive_i}} & pair_hot;
      clk_lvl_q    <= dbg_en_q & clk_s2_q[pair_q];
      dat_lvl_q    <= dbg_en_q & dat_s2_q[pair_q];
    end
  end

  assign avs_readdata_o      = rdata_q;
  assign avs_waitrequest_o   = wait_q;
  assign fetch_ready_o       = ready_q;
  assign dec_valid_o         = dec_valid_q;
  assign dec_o               = dec_q;
  assign nop_cycle_o         = nop_q;
  assign squash_o            = squash_q;
  assign flags_o             = flags_q;
  assign ram_guard_o         = guard_q;
  assign pair_claim_o        = pair_claim_q;
  assign debug_data_pin_o    = data_pin_q;
  assign debug_data_pin_oe_o = data_oe_q;
  assign dbg_clk_level_o     = clk_lvl_q;
  assign dbg_data_level_o    = dat_lvl_q;

endmodule

// ===== hw/cidt_map.svh
`ifndef CIDT_MAP_SVH
`define CIDT_MAP_SVH

// Register byte offsets on the Avalon-MM slave
`define CIDT_REG_CTRL       5'h00
`define CIDT_REG_STATUS     5'h04
`define CIDT_REG_LASTWORD   5'h08
`define CIDT_REG_RETIRED    5'h0c

// Control register fields and reset values
`define CIDT_CTRL_DBG_EN    0
`define CIDT_CTRL_PAIR_LO   1
`define CIDT_CTRL_PAIR_HI   2
`define CIDT_RST_DBG_EN     1'h0
`define CIDT_RST_PAIR       2'h0
`define CIDT_PAIR_COUNT     2'h3

// Status register fields
`define CIDT_STAT_FLAGS_HI  4
`define CIDT_STAT_STATE_LO  8
`define CIDT_STAT_STATE_HI  10
`define CIDT_STAT_ILLEGAL   16

// Opcode byte encodings
`define CIDT_OP_NOP         8'h00
`define CIDT_OP_FILE        8'h10
`define CIDT_OP_BIT_FILE    8'h20
`define CIDT_OP_BIT_WORK    8'h21
`define CIDT_OP_LIT_U       8'h30
`define CIDT_OP_LIT_S       8'h31
`define CIDT_OP_WORK        8'h40
`define CIDT_OP_SQUARE      8'h50
`define CIDT_OP_DSP_MUL     8'h51
`define CIDT_OP_BRA_COND    8'h60
`define CIDT_OP_BRA         8'h61
`define CIDT_OP_BRA_COMP    8'h62
`define CIDT_OP_CALL_IND    8'h63
`define CIDT_OP_GOTO_IND    8'h64
`define CIDT_OP_TABLE       8'h65
`define CIDT_OP_RETURN      8'h66
`define CIDT_OP_RET_INT     8'h67
`define CIDT_OP_SKIP        8'h68
`define CIDT_OP_MOV_DWORD   8'h69
`define CIDT_OP_GOTO        8'h70
`define CIDT_OP_CALL        8'h71
`define CIDT_OP_MOV_LONG    8'h72

// Total instruction cycles per group
`define CIDT_CYC_BRANCH     2'h2
`define CIDT_CYC_INDIRECT   2'h2
`define CIDT_CYC_TABLE      2'h2
`define CIDT_CYC_RETURN     2'h3
`define CIDT_CYC_MOV_DWORD  2'h2
`define CIDT_CYC_SINGLE     2'h1

// Debug resources and literal limits
`define CIDT_RAM_RESV_BYTES 13'h0050
`define CIDT_BYTE_LIT_MAX   10'h0ff

`endif

// ===== hw/cidt_pkg.sv
package cidt_pkg;

  typedef enum logic [4:0] {
    CIDT_CLS_NOP  = 5'h00, CIDT_CLS_FILE = 5'h01, CIDT_CLS_BITF = 5'h02,
    CIDT_CLS_BITW = 5'h03, CIDT_CLS_LITU = 5'h04, CIDT_CLS_LITS = 5'h05,
    CIDT_CLS_WORK = 5'h06, CIDT_CLS_SQR  = 5'h07, CIDT_CLS_DSP  = 5'h08,
    CIDT_CLS_BRC  = 5'h09, CIDT_CLS_BRA  = 5'h0a, CIDT_CLS_IND  = 5'h0b,
    CIDT_CLS_TBL  = 5'h0c, CIDT_CLS_RET  = 5'h0d, CIDT_CLS_SKIP = 5'h0e,
    CIDT_CLS_MOVD = 5'h0f, CIDT_CLS_DBL  = 5'h10, CIDT_CLS_BAD  = 5'h11
  } cidt_cls_t;

  typedef enum logic [1:0] {
    CIDT_SZ_WORD = 2'b00, CIDT_SZ_BYTE = 2'b01, CIDT_SZ_DWORD = 2'b10
  } cidt_size_t;

  typedef enum logic [2:0] {
    CIDT_ST_IDLE  = 3'b000, CIDT_ST_WORD2 = 3'b001, CIDT_ST_STALL = 3'b010,
    CIDT_ST_SKIP  = 3'b011, CIDT_ST_SKIP2 = 3'b100
  } cidt_state_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic n;
    logic ov;
    logic z;
  } cidt_flags_t;

  typedef struct packed {
    logic [4:0]  we;       // Per-flag write enable, same order as flags
    cidt_flags_t val;
    logic        z_sticky;
  } cidt_flag_upd_t;

  typedef struct packed {
    logic [7:0]  opcode;
    cidt_cls_t   cls;
    logic [12:0] file_addr;
    logic        to_file;
    logic [3:0]  bit_sel;
    logic [9:0]  ulit10;
    logic [15:0] signed_ten_literal;
    logic [22:0] prog_addr;
    logic [3:0]  base_work_reg;
    logic [3:0]  source_work_reg;
    logic [3:0]  dest_work_reg;
    cidt_size_t  size;
    logic        mul_ok;
    logic        bad;
  } cidt_dec_t;

endpackage

// ===== sim/cidt_chk_sva.sv
`timescale 1ns/10ps
module cidt_chk (
  input wire logic                clk_i,         // Clock
  input wire logic                rst_i,         // Reset
  input wire logic                fetch_valid_i, // Offer
  input wire logic [23:0]         fetch_word_i,  // Word
  input wire logic                fetch_ready_o, // Accept
  input wire logic                cond_true_i,   // Test
  input wire logic                dec_valid_o,   // Decoded
  input wire cidt_pkg::cidt_dec_t dec_o,         // Fields
  input wire logic                nop_cycle_o,   // Stall
  input wire logic                squash_o       // Dropped
);
  // A squashed word never stalls, so each cost check lets it pass
  wire       tk = fetch_valid_i && fetch_ready_o;
  wire [7:0] op = fetch_word_i[23:16];
  wire       dv = dec_valid_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  jump_stall_a:
    assert property (tk && op == 8'h61 |=> squash_o or
      (nop_cycle_o && !fetch_ready_o ##1 !nop_cycle_o)) else $error("jump");
  return_stall_a:
    assert property (tk && op == 8'h66 |=> squash_o or
      (nop_cycle_o[*2] ##1 !nop_cycle_o)) else $error("return cost");
  cond_cost_a:
    assert property (tk && op == 8'h60 |=> squash_o ||
      nop_cycle_o == $past(cond_true_i)) else $error("cond cost");
  double_cost_a:
    assert property (tk && op inside {8'h70, 8'h71, 8'h72} |=>
      !nop_cycle_o && !dv) else $error("double word cost");
  move_cost_a:
    assert property (tk && op == 8'h69 |=> squash_o or
      (nop_cycle_o ##1 !nop_cycle_o)) else $error("move cost");
  file_field_a:
    assert property (dv && dec_o.cls == cidt_pkg::CIDT_CLS_FILE |->
      dec_o.file_addr == $past(fetch_word_i[12:0])) else $error("file addr");
  opcode_field_a:
    assert property (dv && dec_o.cls != cidt_pkg::CIDT_CLS_DBL |->
      dec_o.opcode == $past(op)) else $error("opcode field");
  square_pair_a:
    assert property (dv && dec_o.cls == cidt_pkg::CIDT_CLS_SQR |->
      dec_o.mul_ok == ($past(fetch_word_i[3:2]) == $past(fetch_word_i[1:0])))
      else $error("square pair");
  signed_lit_a:
    assert property (dv && dec_o.cls == cidt_pkg::CIDT_CLS_LITS |->
      $signed(dec_o.signed_ten_literal) == $signed($past(fetch_word_i[13:4])))
      else $error("signed literal");
endmodule
bind cidt_decoder cidt_chk cidt_chk_i (.clk_i, .rst_i, .fetch_valid_i,
  .fetch_word_i, .fetch_ready_o, .cond_true_i, .dec_valid_o, .dec_o,
  .nop_cycle_o, .squash_o);

// ===== sim/cidt_decoder_tb.sv
`timescale 1ns/10ps
module cidt_decoder_tb;
  logic                     clk_i, rst_i, avs_read_i, avs_write_i;
  logic                     cond_true_i, dbg_data_out_i, dbg_data_drive_i;
  logic                     fetch_valid_i, fetch_ready_o, dec_valid_o;
  logic                     avs_waitrequest_o, nop_cycle_o, squash_o;
  logic                     ram_guard_o, dbg_clk_level_o, dbg_data_level_o;
  logic [4:0]               avs_address_i;
  logic [31:0]              avs_writedata_i, avs_readdata_o, rdat;
  logic [23:0]              fetch_word_i;
  logic [2:0]               debug_clock_pin_i, pair_claim_o;
  logic [2:0]               debug_data_pin_o, debug_data_pin_oe_o;
  cidt_pkg::cidt_flag_upd_t flag_upd_i;
  cidt_pkg::cidt_dec_t      dec_o;
  cidt_pkg::cidt_flags_t    flags_o;
  int                       fails = 0, n_tests = 0, cyc = 0, top = 0;
  int                       nd = 0, nn = 0, ns = 0, ng = 0;
  // Undriven data pins float high
  wire  [2:0]               pin_w = ~debug_data_pin_oe_o | debug_data_pin_o;
  cidt_decoder cidt_decoder_i (
    .clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
    .avs_waitrequest_o, .fetch_valid_i, .fetch_word_i, .fetch_ready_o,
    .cond_true_i, .flag_upd_i, .dec_valid_o, .dec_o, .nop_cycle_o,
    .squash_o, .flags_o, .ram_guard_o, .pair_claim_o, .debug_clock_pin_i,
    .debug_data_pin_i(pin_w), .debug_data_pin_o, .debug_data_pin_oe_o,
    .dbg_data_out_i, .dbg_data_drive_i, .dbg_clk_level_o,
    .dbg_data_level_o);
  cidt_pmem cidt_pmem_i (.clk_i, .rst_i, .ready_i(fetch_ready_o),
    .valid_o(fetch_valid_i), .word_o(fetch_word_i));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task conclude;
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One Avalon access; caller enters just after a rising edge
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    // Wait state and read data are both taken at the rising edge
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    rdat = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task put(input logic [23:0] w);
    cidt_pmem_i.mem[top] = w;
    top++;
  endtask
  // Release queued words and compare the event tallies
  task go(input logic c, input int d, input int n, input int s);
    int d0, n0, s0;
    d0 = nd;
    n0 = nn;
    s0 = ns;
    cond_true_i <= c;
    cidt_pmem_i.lim <= 5'(top);
    @(posedge clk_i);
    while (cidt_pmem_i.ptr_q != 5'(top)) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    chk(nd - d0, d);
    chk(nn - n0, n);
    chk(ns - s0, s);
  endtask
  // Tally decode events; the ceiling cuts a hung run short
  always @(posedge clk_i) begin
    cyc++;
    if (!rst_i && dec_valid_o === 1'b1) nd++;
    if (!rst_i && nop_cycle_o === 1'b1) nn++;
    if (!rst_i && squash_o === 1'b1) ns++;
    if (!rst_i && ram_guard_o === 1'b1) ng++;
    if (cyc > 3000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    {rst_i, avs_read_i, avs_write_i, cond_true_i} = 4'h8;
    {dbg_data_out_i, dbg_data_drive_i} = 2'h0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    debug_clock_pin_i = 3'h0;
    flag_upd_i = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    put(24'h610000); put(24'h660000); put(24'h690000); put(24'h700002);
    put(24'h000001); put(24'h600000); put(24'h101234);
    go(1'b1, 6, 5, 0);
    put(24'h680000); put(24'h710000); put(24'h000000); put(24'h680000);
    put(24'h400123); put(24'h100000);
    go(1'b1, 3, 0, 3);
    put(24'h600000); put(24'h680000); put(24'h50000f); put(24'h510007);
    put(24'h31e005); put(24'h001234);
    go(1'b0, 6, 0, 0);
    chk(dec_o.cls, cidt_pkg::CIDT_CLS_NOP);
    flag_upd_i <= {5'h1f, 5'h1f, 1'b0};
    repeat (2) @(posedge clk_i);
    chk(flags_o, 32'h1f);
    flag_upd_i <= {5'h1f, 5'h00, 1'b1};
    repeat (2) @(posedge clk_i);
    flag_upd_i <= {5'h1f, 5'h1f, 1'b1};
    repeat (2) @(posedge clk_i);
    flag_upd_i <= '0;
    bus(1'b0, 5'h04, 32'h0);
    chk(rdat[4:0], 32'h1e);
    bus(1'b0, 5'h0c, 32'h0);
    chk(rdat, 32'hf);
    bus(1'b0, 5'h10, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b1, 5'h00, 32'h3);
    bus(1'b1, 5'h00, 32'h7);
    bus(1'b0, 5'h00, 32'h0);
    chk(rdat, 32'h3);
    chk(pair_claim_o, 32'h2);
    debug_clock_pin_i <= 3'h2;
    // Driving a low lets only the selected pair read back zero
    {dbg_data_out_i, dbg_data_drive_i} <= 2'h1;
    repeat (5) @(posedge clk_i);
    chk(dbg_clk_level_o, 32'h1);
    chk(debug_data_pin_oe_o, 32'h2);
    chk(dbg_data_level_o, 32'h0);
    put(24'h10004f); put(24'h100050); put(24'h700003); put(24'h000000);
    go(1'b0, 3, 0, 0);
    chk(ng, 32'h1);
    bus(1'b0, 5'h04, 32'h0);
    chk(rdat[16], 32'h1);
    conclude();
  end
endmodule

// ===== sim/cidt_pmem.sv
`timescale 1ns/10ps
module cidt_pmem (
  input  wire logic        clk_i,   // Clock
  input  wire logic        rst_i,   // Reset
  input  wire logic        ready_i, // Word taken
  output logic             valid_o, // Word offered
  output logic      [23:0] word_o   // Program word
);
  logic [23:0] mem [32];
  logic [4:0]  lim = 5'h00;
  logic [4:0]  ptr_q;
  logic [23:0] last_q = 24'h000000;
  // Idle bus shows the inverse of the last word, never a stale copy
  assign valid_o = ptr_q != lim;
  assign word_o  = valid_o ? mem[ptr_q] : ~last_q;
  // Advance only on an accepted word
  always @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= 5'h00;
    end else if (valid_o && ready_i) begin
      ptr_q  <= ptr_q + 5'h01;
      last_q <= word_o;
    end
  end
endmodule
